/* File: hw/isc_params.svh */
// constants of the two-wire target control port
// Summary of operation
// - match address bits against chip-select pins
// - bytes of eight bits, MSB first
// - receiver acknowledges after eight data bits
// - SDA edges while SCL high: start, stop
// - data changes only while SCL low
// - acknowledge holds SDA low whole period
// - no byte limit; host stops the transfer
// - first write byte is the subaddress
// - second write's first byte replaces subaddress
// - acknowledge every received write data byte
// - loader and target port never both enabled
// - fall back to target port on failure
// - drive boot indicator low when ready
// - record memory read error in status
// - during reset ignore bus, lines released
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

`define ISC_ADDR_UPPER 5'h0D
`define ISC_LAST_BIT 3'h7
`define ISC_SYS_MHZ 25
`define ISC_BUSLOW_US 1000
`define ISC_BUSLOW_CYCLES (`ISC_BUSLOW_US * `ISC_SYS_MHZ)
`define ISC_STATUS_SUBADDR 8'h00
`define ISC_ST_MEMERR 0
`define ISC_ST_NODEV 1
`define ISC_ST_BUSLOW 2
`define ISC_ST_LOADED 3
`define ISC_STATUS_RST 8'h00

`endif

/* File: hw/isc_pkg.sv */
// types shared by the target control port
`default_nettype none
package isc_pkg;
	typedef enum logic [1:0] {
		BOOT_LOAD,
		BOOT_DEFAULT,
		BOOT_READY
	} isc_boot_e;
	typedef enum logic [3:0] {
		L_IDLE,
		L_ADDR,
		L_ACKA,
		L_WRITE,
		L_ACKW,
		L_RDWAIT,
		L_READ,
		L_RDACK,
		L_IGNORE
	} isc_link_e;
	typedef enum logic [1:0] {
		EV_SUB,
		EV_DATA,
		EV_READ
	} isc_evt_e;
endpackage
`default_nettype wire

/* File: hw/isc_sync.sv */
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ns
`default_nettype none
module isc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule
`default_nettype wire

/* File: hw/isc_control_port.sv */
// two-wire target control port with boot hand-over and status
`timescale 1ns/1ns
`default_nettype none
`include "isc_params.svh"
module isc_control_port #(
	parameter int BUSLOW_CYCLES = `ISC_BUSLOW_CYCLES
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_link,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic chipSelectBitLow,
	input wire logic chipSelectBitHigh,
	output logic bootIndicatorOut,
	output logic bootIndicatorOe,
	output logic loaderEnable,
	output logic targetEnable,
	input wire logic loaderDone,
	input wire logic loaderNoDevice,
	input wire logic loaderMemError,
	input wire logic initDone,
	output logic [7:0] statusByte,
	output logic wrStrobe,
	output logic [7:0] wrAddr,
	output logic [7:0] wrData,
	output logic rdStrobe,
	output logic [7:0] rdAddr,
	input wire logic [7:0] rdData
);
	import isc_pkg::*;

	localparam int BLW = $clog2(BUSLOW_CYCLES + 1);

	// system-clock side
	logic [2:0] sysSync;
	logic sclLowSys;
	logic sdaLowSys;
	logic tgtEnSys_reg;
	logic evtTglSys;
	isc_boot_e boot_reg;
	logic [BLW-1:0] busLowCnt_reg;
	logic busLowHit;
	logic [7:0] status_reg;
	logic [7:0] ptr_reg;
	logic evtSeen_reg;
	logic evtNew;
	logic rdAckTgl_reg;
	logic [7:0] txHold_reg;
	logic wrStrobe_reg;
	logic [7:0] wrAddr_reg;
	logic [7:0] wrData_reg;
	logic rdStrobe_reg;

	// link-clock side
	logic [5:0] lnkSync;
	logic csLowL;
	logic csHighL;
	logic sclL;
	logic sdaL;
	logic tgtEnL;
	logic rdAckL;
	logic sclP_reg;
	logic sdaP_reg;
	logic startDet;
	logic stopDet;
	logic sclRise;
	logic sclFall;
	logic addrMatch;
	isc_link_e lnk_reg;
	logic [2:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic byteFull_reg;
	logic rw_reg;
	logic first_reg;
	logic acked_reg;
	logic sdaLow_reg;
	logic sclLow_reg;
	logic rdSeen_reg;
	logic evtTgl_reg;
	isc_evt_e evtKind_reg;
	logic [7:0] evtByte_reg;

	isc_sync #(
		.WIDTH(3)
	) uSysSync (
		.clk(clk_sys),
		.arst_n(arst_n),
		.din({evtTgl_reg, ~sdaIn, ~sclIn}),
		.dout(sysSync)
	);
	// lines cross as low flags so the flops' reset value reads as an idle bus
	assign sclLowSys = sysSync[0];
	assign sdaLowSys = sysSync[1];
	assign evtTglSys = sysSync[2];

	// both lines low for the hold time forces the fall-back
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			busLowCnt_reg <= '0;
		else if (boot_reg != BOOT_LOAD || !sclLowSys || !sdaLowSys)
			busLowCnt_reg <= '0;
		else if (!busLowHit)
			busLowCnt_reg <= busLowCnt_reg + 1'b1;
	end
	assign busLowHit = (busLowCnt_reg == BLW'(BUSLOW_CYCLES));

	// boot hand-over: one state decides which port is live
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			boot_reg <= BOOT_LOAD;
		else
		begin
			case (boot_reg)
				BOOT_LOAD:
					if (loaderDone || loaderNoDevice || loaderMemError || busLowHit)
						boot_reg <= BOOT_DEFAULT;
				BOOT_DEFAULT:
					if (initDone)
						boot_reg <= BOOT_READY;
				default:
					boot_reg <= BOOT_READY;
			endcase
		end
	end

	assign loaderEnable = (boot_reg == BOOT_LOAD);
	assign targetEnable = (boot_reg != BOOT_LOAD);
	// pin is an input until the port is ready, then an output held low
	assign bootIndicatorOut = 1'b0;
	assign bootIndicatorOe = (boot_reg == BOOT_READY);

	// the state decode may glitch between codes, so the link side gets a flop
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			tgtEnSys_reg <= 1'b0;
		else
			tgtEnSys_reg <= (boot_reg != BOOT_LOAD);
	end

	// status is settled before the port comes up, so the host reads a final result
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			status_reg <= `ISC_STATUS_RST;
		else if (boot_reg == BOOT_LOAD)
		begin
			if (loaderMemError)
				status_reg[`ISC_ST_MEMERR] <= 1'b1;
			if (loaderNoDevice)
				status_reg[`ISC_ST_NODEV] <= 1'b1;
			if (busLowHit)
				status_reg[`ISC_ST_BUSLOW] <= 1'b1;
			if (loaderDone && !loaderMemError)
				status_reg[`ISC_ST_LOADED] <= 1'b1;
		end
	end
	assign statusByte = status_reg;

	// link events arrive by toggle; their byte and kind are held stable long after
	assign evtNew = (evtTglSys != evtSeen_reg);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			evtSeen_reg <= 1'b0;
			ptr_reg <= 8'h00;
			wrStrobe_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
			wrData_reg <= 8'h00;
			rdStrobe_reg <= 1'b0;
			txHold_reg <= 8'h00;
			rdAckTgl_reg <= 1'b0;
		end
		else
		begin
			evtSeen_reg <= evtTglSys;
			wrStrobe_reg <= 1'b0;
			rdStrobe_reg <= 1'b0;
			if (evtNew)
			begin
				case (evtKind_reg)
					EV_SUB:
						ptr_reg <= evtByte_reg;
					EV_DATA:
					begin
						wrStrobe_reg <= 1'b1;
						wrAddr_reg <= ptr_reg;
						wrData_reg <= evtByte_reg;
						ptr_reg <= ptr_reg + 8'h01;
					end
					default:
					begin
						// reads continue from the pointer: the last subaddress plus one for each byte moved since
						txHold_reg <= (ptr_reg == `ISC_STATUS_SUBADDR) ? status_reg : rdData;
						rdStrobe_reg <= 1'b1;
						ptr_reg <= ptr_reg + 8'h01;
						rdAckTgl_reg <= ~rdAckTgl_reg;
					end
				endcase
			end
		end
	end
	assign wrStrobe = wrStrobe_reg;
	assign wrAddr = wrAddr_reg;
	assign wrData = wrData_reg;
	assign rdStrobe = rdStrobe_reg;
	assign rdAddr = ptr_reg;

	isc_sync #(
		.WIDTH(6)
	) uLnkSync (
		.clk(clk_link),
		.arst_n(arst_n),
		.din({chipSelectBitHigh, chipSelectBitLow, rdAckTgl_reg, tgtEnSys_reg, sdaIn, sclIn}),
		.dout(lnkSync)
	);
	assign sclL = lnkSync[0];
	assign sdaL = lnkSync[1];
	assign tgtEnL = lnkSync[2];
	assign rdAckL = lnkSync[3];
	assign csLowL = lnkSync[4];
	assign csHighL = lnkSync[5];

	always_ff @(posedge clk_link or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclP_reg <= 1'b1;
			sdaP_reg <= 1'b1;
		end
		else
		begin
			sclP_reg <= sclL;
			sdaP_reg <= sdaL;
		end
	end

	assign startDet = sclL && sclP_reg && sdaP_reg && !sdaL;
	assign stopDet = sclL && sclP_reg && !sdaP_reg && sdaL;
	assign sclRise = sclL && !sclP_reg;
	assign sclFall = !sclL && sclP_reg;
	assign addrMatch = (shift_reg[7:1] == {`ISC_ADDR_UPPER, csHighL, csLowL});

	// line drive changes happen on a falling SCL edge or while the target itself holds SCL low
	always_ff @(posedge clk_link or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lnk_reg <= L_IDLE;
			bitCnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			byteFull_reg <= 1'b0;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			acked_reg <= 1'b0;
			sdaLow_reg <= 1'b0;
			sclLow_reg <= 1'b0;
			rdSeen_reg <= 1'b0;
			evtTgl_reg <= 1'b0;
			evtKind_reg <= EV_SUB;
			evtByte_reg <= 8'h00;
		end
		else if (!tgtEnL)
		begin
			lnk_reg <= L_IDLE;
			sdaLow_reg <= 1'b0;
			sclLow_reg <= 1'b0;
			rdSeen_reg <= rdAckL;
		end
		else if (startDet)
		begin
			lnk_reg <= L_ADDR;
			bitCnt_reg <= 3'h0;
			byteFull_reg <= 1'b0;
			sdaLow_reg <= 1'b0;
			sclLow_reg <= 1'b0;
		end
		else if (stopDet)
		begin
			lnk_reg <= L_IDLE;
			sdaLow_reg <= 1'b0;
			sclLow_reg <= 1'b0;
		end
		else
		begin
			case (lnk_reg)
				L_ADDR, L_WRITE:
				begin
					if (sclRise)
					begin
						shift_reg <= {shift_reg[6:0], sdaL};
						bitCnt_reg <= bitCnt_reg + 3'h1;
						byteFull_reg <= (bitCnt_reg == `ISC_LAST_BIT);
					end
					else if (sclFall && byteFull_reg)
					begin
						byteFull_reg <= 1'b0;
						if (lnk_reg == L_ADDR)
						begin
							if (addrMatch)
							begin
								lnk_reg <= L_ACKA;
								sdaLow_reg <= 1'b1;
								rw_reg <= shift_reg[0];
								first_reg <= 1'b1;
							end
							else
								lnk_reg <= L_IGNORE;
						end
						else
						begin
							lnk_reg <= L_ACKW;
							sdaLow_reg <= 1'b1;
							first_reg <= 1'b0;
							evtKind_reg <= first_reg ? EV_SUB : EV_DATA;
							evtByte_reg <= shift_reg;
							evtTgl_reg <= ~evtTgl_reg;
						end
					end
				end
				L_ACKA:
					if (sclFall)
					begin
						sdaLow_reg <= 1'b0;
						bitCnt_reg <= 3'h0;
						if (rw_reg)
						begin
							// stretch SCL until the byte to send has crossed over
							lnk_reg <= L_RDWAIT;
							sclLow_reg <= 1'b1;
							evtKind_reg <= EV_READ;
							evtTgl_reg <= ~evtTgl_reg;
						end
						else
							lnk_reg <= L_WRITE;
					end
				L_ACKW:
					if (sclFall)
					begin
						sdaLow_reg <= 1'b0;
						bitCnt_reg <= 3'h0;
						lnk_reg <= L_WRITE;
					end
				L_RDWAIT:
					if (rdAckL != rdSeen_reg)
					begin
						rdSeen_reg <= rdAckL;
						sdaLow_reg <= !txHold_reg[7];
						shift_reg <= {txHold_reg[6:0], 1'b0};
						bitCnt_reg <= 3'h0;
						lnk_reg <= L_READ;
					end
				L_READ:
					// the stretch ends one cycle after the first bit, never with it
					if (sclLow_reg)
						sclLow_reg <= 1'b0;
					else if (sclFall)
					begin
						bitCnt_reg <= bitCnt_reg + 3'h1;
						if (bitCnt_reg == `ISC_LAST_BIT)
						begin
							sdaLow_reg <= 1'b0;
							lnk_reg <= L_RDACK;
						end
						else
						begin
							sdaLow_reg <= !shift_reg[7];
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
				L_RDACK:
					if (sclRise)
						acked_reg <= !sdaL;
					else if (sclFall)
					begin
						if (acked_reg)
						begin
							lnk_reg <= L_RDWAIT;
							sclLow_reg <= 1'b1;
							evtKind_reg <= EV_READ;
							evtTgl_reg <= ~evtTgl_reg;
						end
						else
							lnk_reg <= L_IGNORE;
					end
				default:
					sdaLow_reg <= 1'b0;
			endcase
		end
	end

	// open-drain: only ever pull low
	assign sdaOut = 1'b0;
	assign sclOut = 1'b0;
	assign sdaOe = sdaLow_reg;
	assign sclOe = sclLow_reg;

	a_ports_exclusive: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!(loaderEnable && targetEnable))
		else $error("loader and target port enabled together");

	a_indicator_ready: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(boot_reg == BOOT_DEFAULT && initDone) |=> bootIndicatorOe && !bootIndicatorOut)
		else $error("boot indicator not driven low after init");

	a_memerr_status: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(boot_reg == BOOT_LOAD && loaderMemError) |=> status_reg[`ISC_ST_MEMERR]
		##1 targetEnable)
		else $error("memory error not recorded or port not handed over");

	a_buslow_fallback: assert property (@(posedge clk_sys) disable iff (!arst_n)
		busLowHit |=> targetEnable && status_reg[`ISC_ST_BUSLOW])
		else $error("bus-low fall-back not taken");

	a_sub_replace: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(evtNew && evtKind_reg == EV_SUB) |=> ptr_reg == $past(evtByte_reg) && !wrStrobe)
		else $error("first write byte not taken as subaddress");

	a_addr_ack: assert property (@(posedge clk_link) disable iff (!arst_n)
		(lnk_reg == L_ACKA) |-> sdaOe && !sclOe)
		else $error("address acknowledge not held for the whole period");

	a_write_ack: assert property (@(posedge clk_link) disable iff (!arst_n)
		(lnk_reg == L_WRITE && sclFall && byteFull_reg && tgtEnL && !startDet && !stopDet)
		|=> sdaOe && lnk_reg == L_ACKW)
		else $error("write data byte not acknowledged");

	a_nomatch_quiet: assert property (@(posedge clk_link) disable iff (!arst_n)
		(lnk_reg == L_IGNORE) |-> !sdaOe && !sclOe)
		else $error("line driven after address mismatch");

	a_sda_scl_low: assert property (@(posedge clk_link) disable iff (!arst_n)
		($changed(sdaLow_reg) && $past(tgtEnL)) |-> !$past(sclL))
		else $error("data line changed while clock high");

	a_read_stretch: assert property (@(posedge clk_link) disable iff (!arst_n)
		(lnk_reg == L_RDACK && sclFall && acked_reg && tgtEnL && !startDet && !stopDet)
		|=> sclOe ##[1:40] !sclOe)
		else $error("next read byte not fetched after host acknowledge");
endmodule
`default_nettype wire

/* File: sim/isc_host.sv */
// two-wire bus host model that honours clock stretching
`timescale 1ns/1ns
`default_nettype none
module isc_host (
	input wire logic clkLink,
	input wire logic scl,
	input wire logic sda,
	output logic sclLow,
	output logic sdaLow
);
	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clkLink);
	endtask
	// the target may hold the clock low, so follow the wire, bounded
	task automatic sclUp();
		int k;
		sclLow <= 1'b0;
		for (k = 0; k < 2000 && scl !== 1'b1; k++)
			tick(1);
		tick(6);
	endtask
	task automatic start();
		tick(1);
		sdaLow <= 1'b0;
		tick(4);
		sclUp();
		sdaLow <= 1'b1;
		tick(6);
		sclLow <= 1'b1;
		tick(4);
	endtask
	task automatic stop();
		sdaLow <= 1'b1;
		tick(4);
		sclUp();
		sdaLow <= 1'b0;
		tick(6);
	endtask
	// eight bits then the acknowledge slot; data moves only with the clock low
	task automatic xfer(input logic [7:0] d, input logic ackBit, output logic [7:0] q,
		output logic ackSeen);
		logic [8:0] sh;
		int i;
		sh = {d, ackBit};
		for (i = 8; i >= 0; i--)
		begin
			sdaLow <= ~sh[i];
			tick(4);
			sclUp();
			sh[i] = sda;
			sclLow <= 1'b1;
			tick(4);
		end
		q = sh[8:1];
		ackSeen = sh[0];
	endtask
	task automatic holdLow(input int n);
		tick(1);
		sdaLow <= 1'b1;
		sclLow <= 1'b1;
		tick(n);
		sclLow <= 1'b0;
		tick(4);
		sdaLow <= 1'b0;
		tick(4);
	endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// testbench of the two-wire target control port
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int LOWCYC = 20;
	logic clkSys, clkLink, arst_n, sclOe, sdaOe, csLow, csHigh, bootOut, bootOe;
	logic loaderEnable, targetEnable, ldDone, ldNoDev, ldMemErr, initDone, wrStrobe;
	logic rdStrobe, sclOut, sdaOut;
	logic hostSclLow, hostSdaLow, scl, sda, ackSeen;
	logic [7:0] statusByte, wrAddr, wrData, rdAddr, rdData, q;
	// subaddress, first data, second data, address of the second data
	logic [31:0] rows [4] = '{32'h0100FF02, 32'h7F5AA580, 32'hFE8001FF, 32'h10C33C11};
	logic [15:0] wq [$];
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int nRd = 0;
	int i;
	assign scl = ~(hostSclLow | sclOe);
	assign sda = ~(hostSdaLow | sdaOe);
	assign rdData = rdAddr ^ 8'hA5;
	initial
	begin
		clkSys = 1'b0;
		forever #20 clkSys = ~clkSys;
	end
	initial
	begin
		clkLink = 1'b0;
		#7;
		forever #6 clkLink = ~clkLink;
	end
	isc_control_port #(.BUSLOW_CYCLES(LOWCYC)) isc_control_port_i (
		.clk_sys(clkSys), .arst_n(arst_n), .clk_link(clkLink), .sclIn(scl), .sclOut(sclOut),
		.sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectBitLow(csLow),
		.chipSelectBitHigh(csHigh), .bootIndicatorOut(bootOut), .bootIndicatorOe(bootOe),
		.loaderEnable(loaderEnable), .targetEnable(targetEnable), .loaderDone(ldDone),
		.loaderNoDevice(ldNoDev), .loaderMemError(ldMemErr), .initDone(initDone),
		.statusByte(statusByte), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData),
		.rdStrobe(rdStrobe), .rdAddr(rdAddr), .rdData(rdData));
	isc_host isc_host_i (.clkLink(clkLink), .scl(scl), .sda(sda), .sclLow(hostSclLow),
		.sdaLow(hostSdaLow));
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clkSys)
	begin
		cyc++;
		if (wrStrobe === 1'b1)
			wq.push_back({wrAddr, wrData});
		if (rdStrobe === 1'b1)
			nRd++;
		if (cyc == 20000)
		begin
			err_total++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] st();
		return {sclOut, sdaOut, 1'b0, loaderEnable, targetEnable, sdaOe, sclOe, bootOe, statusByte};
	endfunction
	task automatic send(input logic [7:0] b, input logic expAck);
		isc_host_i.xfer(b, 1'b1, q, ackSeen);
		chk({15'h0, ackSeen}, {15'h0, ~expAck});
	endtask
	task automatic recv(input logic nack, input logic [7:0] exp);
		isc_host_i.xfer(8'hFF, nack, q, ackSeen);
		chk({8'h0, q}, {8'h0, exp});
	endtask
	task automatic doReset();
		@(posedge clkSys);
		arst_n <= 1'b0;
		repeat (3) @(posedge clkSys);
		arst_n <= 1'b1;
		@(posedge clkSys);
		#1;
		chk(st(), 16'h1000);
	endtask
	task automatic waitWrites(input int n);
		repeat (10) @(posedge clkSys);
		chk(16'(wq.size()), 16'(n));
	endtask
	initial
	begin
		arst_n = 1'b0;
		csLow = 1'b0;
		csHigh = 1'b0;
		ldDone = 1'b0;
		ldNoDev = 1'b0;
		ldMemErr = 1'b0;
		initDone = 1'b0;
		doReset();
		@(posedge clkSys);
		ldMemErr <= 1'b1;
		@(posedge clkSys);
		ldMemErr <= 1'b0;
		#1;
		chk(st(), 16'h0801);
		@(posedge clkSys);
		initDone <= 1'b1;
		@(posedge clkSys);
		initDone <= 1'b0;
		for (i = 0; i < 4 && bootOe !== 1'b1; i++)
			@(posedge clkSys);
		#1;
		chk({14'h0, bootOut, bootOe}, 16'h0001);
		repeat (5) @(posedge clkSys);
		$display("test boot finished");
		for (i = 0; i < 4; i++)
		begin
			wq.delete();
			isc_host_i.start();
			send(8'h68, 1'b1);
			send(rows[i][31:24], 1'b1);
			send(rows[i][23:16], 1'b1);
			send(rows[i][15:8], 1'b1);
			isc_host_i.stop();
			waitWrites(2);
			chk(wq[0], rows[i][31:16]);
			chk(wq[1], {rows[i][7:0], rows[i][15:8]});
		end
		$display("test row writes finished");
		wq.delete();
		isc_host_i.start();
		send(8'h6A, 1'b0);
		send(8'h10, 1'b0);
		isc_host_i.stop();
		@(posedge clkSys);
		csLow <= 1'b1;
		isc_host_i.start();
		send(8'h6A, 1'b1);
		send(8'h20, 1'b1);
		send(8'h99, 1'b1);
		isc_host_i.stop();
		@(posedge clkSys);
		csLow <= 1'b0;
		csHigh <= 1'b1;
		isc_host_i.start();
		send(8'h6C, 1'b1);
		send(8'h21, 1'b1);
		send(8'h55, 1'b1);
		isc_host_i.stop();
		@(posedge clkSys);
		csHigh <= 1'b0;
		waitWrites(2);
		chk(wq[0], 16'h2099);
		chk(wq[1], 16'h2155);
		$display("test address match finished");
		wq.delete();
		isc_host_i.start();
		send(8'h68, 1'b1);
		send(8'h30, 1'b1);
		isc_host_i.stop();
		isc_host_i.start();
		send(8'h68, 1'b1);
		send(8'h40, 1'b1);
		send(8'h77, 1'b1);
		isc_host_i.stop();
		waitWrites(1);
		chk(wq[0], 16'h4077);
		$display("test subaddress replace finished");
		isc_host_i.start();
		send(8'h68, 1'b1);
		send(8'h00, 1'b1);
		isc_host_i.start();
		send(8'h69, 1'b1);
		recv(1'b0, 8'h01);
		recv(1'b1, 8'hA4);
		isc_host_i.stop();
		chk(16'(nRd), 16'h0002);
		$display("test read finished");
		doReset();
		isc_host_i.holdLow(150);
		@(posedge clkSys);
		#1;
		chk(st(), 16'h0804);
		$display("test bus low fallback finished");
		doReset();
		@(posedge clkSys);
		ldNoDev <= 1'b1;
		@(posedge clkSys);
		ldNoDev <= 1'b0;
		#1;
		chk(st(), 16'h0802);
		doReset();
		@(posedge clkSys);
		ldDone <= 1'b1;
		@(posedge clkSys);
		ldDone <= 1'b0;
		#1;
		chk(st(), 16'h0808);
		$display("test load results finished");
		final_report();
	end
endmodule
`default_nettype wire
